// File: status_aggregator.sv
// Purpose: Builds the subsystem error bitmap and the indicator code.
// Assumes: All inputs except rst are synchronous to clock.
// Notes:   Measurements are held until a fresh sample arrives.
`timescale 1ns/1ps
`default_nettype none

module status_aggregator
    import stat_pkg::*;
(
    input  wire logic                         clock,     // 25 MHz clock
    input  wire logic                         rst,       // Async reset
    input  wire stat_pkg::link_s              link,      // Link status
    input  wire stat_pkg::word_t [stat_pkg::MEAS_N-1:0] meas,   // Samples
    input  wire logic [stat_pkg::MEAS_N-1:0]  meas_upd,  // Sample strobes
    input  wire logic                         jam_clear, // Recovery done
    input  wire logic                         rd_en,     // Read request
    input  wire stat_pkg::word_t              rd_addr,   // Register number
    output var  stat_pkg::word_t              rd_data,   // Read data
    output var  logic                         rd_valid,  // Read answer
    output var  stat_pkg::word_t              err_bits,  // Error bitmap
    output var  stat_pkg::word_t              ind_code   // Indicator code
);
    import stat_pkg::*;

    localparam word_t MEAS_RST [MEAS_N] =
        '{RST_BATT, RST_SUP36, RST_MOTOR, RST_TEMP, RST_SUP5};

    // ======================================================================
    // Held measurements
    // ======================================================================
    word_t meas_r   [MEAS_N];
    word_t meas_nxt [MEAS_N];
    // Packed copy of the held samples so the hold check can use $past.
    word_t [MEAS_N-1:0] meas_pk;

    // A lost link simply stops the strobes, so the old value stays.
    genvar gi;
    generate
        for (gi = 0; gi < MEAS_N; gi++) begin : g_hold
            assign meas_pk[gi] = meas_r[gi];
            always_comb begin
                meas_nxt[gi] = meas_upd[gi] ? meas[gi] : meas_r[gi];
            end
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meas_r[gi] <= MEAS_RST[gi];
                end else begin
                    meas_r[gi] <= meas_nxt[gi];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Limit comparisons
    // ======================================================================
    logic batt_out;
    logic batt_low;
    logic sup36_out;
    logic sup36_show;
    logic temp_out;
    logic sup5_out;
    logic cur_high;
    logic cur_jam;
    logic outside_limits;

    always_comb begin
        batt_out   = (meas_r[M_BATT] < BATT_LO) ||
                     (meas_r[M_BATT] > BATT_HI);
        batt_low   = meas_r[M_BATT] < BATT_WARN;
        sup36_out  = (meas_r[M_SUP36] < SUP36_LO) ||
                     (meas_r[M_SUP36] > SUP36_HI);
        // With the auxiliary output off the rail is expected to be down.
        sup36_show = sup36_out && !link.aux_off;
        temp_out   = ($signed(meas_r[M_TEMP]) < $signed(TEMP_LO)) ||
                     ($signed(meas_r[M_TEMP]) > $signed(TEMP_HI));
        sup5_out   = (meas_r[M_SUP5] < SUP5_LO) ||
                     (meas_r[M_SUP5] > SUP5_HI);
        cur_high   = meas_r[M_MOTOR] > CUR_WARN_MA;
        cur_jam    = meas_r[M_MOTOR] > JAM_MA;
        outside_limits = batt_out || sup36_show ||
                         temp_out || sup5_out;
    end

    // ======================================================================
    // Jam recovery tracking
    // ======================================================================
    jam_e jam_r;
    jam_e jam_nxt;

    // Entry wins over a clear in the same cycle so no trigger is lost.
    always_comb begin
        jam_nxt = jam_r;
        unique case (jam_r)
            JAM_IDLE: begin
                if (cur_jam || link.mot_fault) begin
                    jam_nxt = JAM_RUN;
                end
            end
            JAM_RUN: begin
                if (jam_clear && !cur_jam && !link.mot_fault) begin
                    jam_nxt = JAM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            jam_r <= JAM_IDLE;
        end else begin
            jam_r <= jam_nxt;
        end
    end

    // ======================================================================
    // Status registers
    // ======================================================================
    word_t err_r;
    word_t err_nxt;
    word_t ind_r;
    word_t ind_nxt;

    always_comb begin
        err_nxt              = '0;
        err_nxt[ERR_GPS_BIT] = link.gps_fail;
        err_nxt[ERR_CHG_BIT] = link.chg_fail;
        err_nxt[ERR_MOT_BIT] = link.mot_fail;
        err_nxt[ERR_LIM_BIT] = outside_limits;
    end

    // Yellow codes are sixteen times the blink count.
    // First match wins, so only the highest priority is shown.
    always_comb begin
        if (batt_out) begin
            ind_nxt = IND_RED5;
        end else if (jam_r == JAM_RUN) begin
            ind_nxt = IND_JAM;
        end else if (sup36_show) begin
            ind_nxt = IND_RED2;
        end else if (link.mot_fail && !link.aux_off) begin
            ind_nxt = IND_RED3;
        end else if (link.chg_fail) begin
            ind_nxt = IND_RED4;
        end else if (cur_high) begin
            ind_nxt = IND_YEL1;
        end else if (batt_low) begin
            ind_nxt = IND_YEL2;
        end else if (temp_out) begin
            ind_nxt = IND_YEL3;
        end else if (sup5_out) begin
            ind_nxt = IND_YEL4;
        end else if (link.gps_fail) begin
            ind_nxt = IND_YEL5;
        end else if (link.gps_acq) begin
            ind_nxt = IND_ACQ;
        end else begin
            ind_nxt = IND_OK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_r <= '0;
            ind_r <= IND_OK;
        end else begin
            err_r <= err_nxt;
            ind_r <= ind_nxt;
        end
    end

    // ======================================================================
    // Read port
    // ======================================================================
    word_t rd_data_r;
    word_t rd_data_nxt;
    logic  rd_valid_r;

    // Writes are not possible; unknown register numbers read as zero.
    always_comb begin
        rd_data_nxt = '0;
        if (rd_en && rd_addr == ERR_REG_NUM) begin
            rd_data_nxt = err_r;
        end else if (rd_en && rd_addr == IND_REG_NUM) begin
            rd_data_nxt = ind_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_en;
        end
    end

    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign err_bits = err_r;
    assign ind_code = ind_r;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_err_healthy: assert property (
        !link.gps_fail && !link.chg_fail && !link.mot_fail && !outside_limits
        |=> err_r == 16'h0000)
        else $error("Error bitmap not zero while healthy.");

    // Past values taken inside a reset are not what the bitmap loaded.
    a_err_or_weights: assert property (
        !$past(rst) |-> err_r[3:0] == $past({outside_limits, link.mot_fail,
                                             link.chg_fail, link.gps_fail}))
        else $error("Error bitmap is not the OR of fault weights.");

    a_err_gps_bit: assert property (
        link.gps_fail |=> err_r[0])
        else $error("Receiver link failure not flagged in bit 0.");

    a_err_chg_bit: assert property (
        link.chg_fail |=> err_r[1])
        else $error("Charger link failure not flagged in bit 1.");

    a_err_mot_bit: assert property (
        link.mot_fail |=> err_r[2])
        else $error("Motor link failure not flagged in bit 2.");

    a_err_batt_limit: assert property (
        meas_r[M_BATT] < BATT_LO |=> err_r[3])
        else $error("Battery outside limits not flagged in bit 3.");

    a_ind_batt_top: assert property (
        batt_out |=> ind_r == IND_RED5)
        else $error("Battery fault did not show five red.");

    a_jam_entry: assert property (
        link.mot_fault && !batt_out ##1 !batt_out
        |=> ind_r == IND_JAM)
        else $error("Motor fault did not raise jam indication.");

    a_ind_aux_hide: assert property (
        link.aux_off |=> ind_r != IND_RED2 && ind_r != IND_RED3)
        else $error("Hidden indication shown with auxiliary off.");

    a_ind_gps_cause: assert property (
        ind_r == IND_YEL5 |-> $past(link.gps_fail) && !$past(cur_high))
        else $error("Five yellow shown without receiver fault.");

    a_hold_last: assert property (
        meas_upd == '0 |=> meas_pk == $past(meas_pk))
        else $error("Held measurement changed without a sample.");

    a_read_upper: assert property (
        rd_en && rd_addr == ERR_REG_NUM
        |=> rd_valid_r && rd_data_r[15:4] == 12'h000)
        else $error("Bitmap upper bits not zero on read.");

    a_ind_jam_over: assert property (
        jam_r == JAM_RUN && !batt_out |=> ind_r == IND_JAM)
        else $error("Jam recovery not shown above lower priorities.");

    a_ind_sup36_red: assert property (
        sup36_show && !batt_out && jam_r != JAM_RUN |=> ind_r == IND_RED2)
        else $error("Rail fault did not show two red.");

    a_ind_mot_red: assert property (
        link.mot_fail && !link.aux_off && !batt_out && jam_r != JAM_RUN &&
        !sup36_show |=> ind_r == IND_RED3)
        else $error("Motor link fault did not show three red.");

    a_ind_chg_red: assert property (
        ind_r == IND_RED4 |-> $past(link.chg_fail))
        else $error("Four red shown without charger link fault.");

    a_ind_cur_yel: assert property (
        ind_r == IND_YEL1 |-> $past(cur_high))
        else $error("One yellow shown without high motor current.");

    a_ind_low_batt: assert property (
        ind_r == IND_YEL2 |-> $past(batt_low))
        else $error("Two yellow shown without low battery.");

    a_ind_temp_yel: assert property (
        ind_r == IND_YEL3 |-> $past(temp_out))
        else $error("Three yellow shown without temperature fault.");

    a_ind_sup5_yel: assert property (
        ind_r == IND_YEL4 |-> $past(sup5_out))
        else $error("Four yellow shown without 5 V rail fault.");

endmodule

`default_nettype wire

// File: stat_pkg.sv
// Purpose: Shared constants and carriers for the status aggregator.
// Assumes: Measurements arrive as unsigned scaled integers (temp signed).
// Notes:   Units: volts in tenths (5 V rail in hundredths), current in mA.
`default_nettype none
package stat_pkg;

    typedef logic [15:0] word_t;

    // ======================================================================
    // Register numbers on the polled register link
    // ======================================================================
    localparam word_t ERR_REG_NUM = 16'h0007;
    localparam word_t IND_REG_NUM = 16'h0009;

    // ======================================================================
    // Error bitmap field positions
    // ======================================================================
    localparam int ERR_GPS_BIT = 0;
    localparam int ERR_CHG_BIT = 1;
    localparam int ERR_MOT_BIT = 2;
    localparam int ERR_LIM_BIT = 3;
    localparam int ERR_USED    = 4;

    // ======================================================================
    // Measurement slots, reset values (nominal) and limits
    // ======================================================================
    localparam int MEAS_N   = 5;
    localparam int M_BATT   = 0;  // Battery, 0.1 V units.
    localparam int M_SUP36  = 1;  // 36 V rail, 0.1 V units.
    localparam int M_MOTOR  = 2;  // Motor current, mA.
    localparam int M_TEMP   = 3;  // Temperature, signed deg F.
    localparam int M_SUP5   = 4;  // 5 V rail, 0.01 V units.

    localparam word_t RST_BATT  = 16'h0082;
    localparam word_t RST_SUP36 = 16'h0168;
    localparam word_t RST_MOTOR = 16'h0000;
    localparam word_t RST_TEMP  = 16'h0046;
    localparam word_t RST_SUP5  = 16'h01F4;

    localparam word_t BATT_LO     = 16'h0072;  // 11.4 V
    localparam word_t BATT_HI     = 16'h00AF;  // 17.5 V
    localparam word_t BATT_WARN   = 16'h0079;  // 12.1 V
    localparam word_t SUP36_LO    = 16'h014A;  // 33.0 V
    localparam word_t SUP36_HI    = 16'h0186;  // 39.0 V
    localparam word_t JAM_MA      = 16'h1194;  // 4.5 A
    localparam word_t CUR_WARN_MA = 16'h0DAC;  // 3.5 A
    localparam word_t TEMP_LO     = 16'h0000;  // 0 deg F
    localparam word_t TEMP_HI     = 16'h00B0;  // 176 deg F
    localparam word_t SUP5_LO     = 16'h01C2;  // 4.50 V
    localparam word_t SUP5_HI     = 16'h0226;  // 5.50 V

    // ======================================================================
    // Indicator codes
    // ======================================================================
    localparam word_t IND_OK   = 16'h0000;
    localparam word_t IND_JAM  = 16'h0001;
    localparam word_t IND_RED2 = 16'h0002;
    localparam word_t IND_RED3 = 16'h0003;
    localparam word_t IND_RED4 = 16'h0004;
    localparam word_t IND_RED5 = 16'h0005;
    localparam word_t IND_YEL1 = 16'h0010;
    localparam word_t IND_YEL2 = 16'h0020;
    localparam word_t IND_YEL3 = 16'h0030;
    localparam word_t IND_YEL4 = 16'h0040;
    localparam word_t IND_YEL5 = 16'h0050;
    localparam word_t IND_ACQ  = 16'h0100;

    typedef enum logic {JAM_IDLE, JAM_RUN} jam_e;

    typedef struct packed {
        logic gps_fail;     // Positioning receiver link lost.
        logic chg_fail;     // Charge controller link lost.
        logic mot_fail;     // Motor controller link lost.
        logic mot_fault;    // Fault report pulse from motor controller.
        logic aux_off;      // Charge controller auxiliary output off.
        logic gps_acq;      // Receiver still acquiring satellites.
    } link_s;

endpackage

`default_nettype wire

// File: poll_master.sv
// Purpose: Polling master model for the status register read port.
// Assumes: The answer stands one clock after the request edge.
// Notes:   The address idles inverted so a stale number never matches.
`timescale 1ns/1ps
`default_nettype none
module poll_master
    import stat_pkg::*;
(
    input  wire logic            clock,    // System clock
    input  wire stat_pkg::word_t rd_data,  // Read data
    input  wire logic            rd_valid, // Read answer
    output var  logic            rd_en,    // Read request
    output var  stat_pkg::word_t rd_addr   // Register number
);
    initial begin
        rd_en   = 1'b0;
        rd_addr = 16'hFFFF;
    end

    // ======================================================================
    // Single read
    // ======================================================================
    // A held request would read twice, so the request is one pulse.
    task automatic read(input word_t a, output word_t d, output logic ok);
        ok = 1'b0;
        d  = 16'hDEAD;
        @(negedge clock);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clock);
        rd_en   = 1'b0;
        rd_addr = ~a;
        for (int i = 0; i < 3 && ok !== 1'b1; i++) begin
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d  = rd_data;
            end else begin
                @(negedge clock);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the status aggregator.
// Assumes: Inputs change on the falling edge; results settle in 3 clocks.
// Notes:   Table rows cover the plain cases; jam and reset are by hand.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import stat_pkg::*;

    typedef struct packed {
        link_s              lk;
        word_t [MEAS_N-1:0] m;
        word_t              err;
        word_t              ind;
    } row_s;

    localparam word_t nb = RST_BATT;
    localparam word_t ns = RST_SUP36;
    localparam word_t nm = RST_MOTOR;
    localparam word_t nt = RST_TEMP;
    localparam word_t n5 = RST_SUP5;

    logic               clock;
    logic               rst;
    logic               jam_clear;
    link_s              link;
    word_t [MEAS_N-1:0] meas;
    logic [MEAS_N-1:0]  meas_upd;
    logic               rd_en;
    logic               rd_valid;
    word_t              rd_addr;
    word_t              rd_data;
    word_t              err_bits;
    word_t              ind_code;
    int                 bad_count;
    int                 n_checks;
    int                 cycles;
    row_s               rows [20];

    status_aggregator uut (.clock(clock), .rst(rst), .link(link),
        .meas(meas), .meas_upd(meas_upd), .jam_clear(jam_clear),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .err_bits(err_bits), .ind_code(ind_code));

    poll_master poll (.clock(clock), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_en(rd_en), .rd_addr(rd_addr));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ======================================================================
    // Helpers
    // ======================================================================
    function automatic row_s mk(input logic [5:0] lk,
            input word_t b, s, c, t, f, e, i);
        mk = {lk, f, t, c, s, b, e, i};
    endfunction

    task automatic chk(input string what, input word_t exp, input word_t got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input word_t a, input word_t exp);
        word_t d;
        logic  ok;
        poll.read(a, d, ok);
        chk("rd_valid", 16'h0001, {15'h0000, ok});
        chk("rd_data", exp, d);
    endtask

    task automatic apply(input row_s r);
        @(negedge clock);
        link     = r.lk;
        meas     = r.m;
        meas_upd = 5'h1F;
        @(negedge clock);
        meas_upd = 5'h00;
        repeat (3) @(negedge clock);
    endtask

    task automatic samp(input int slot, input word_t v);
        @(negedge clock);
        meas[slot]     = v;
        meas_upd[slot] = 1'b1;
        @(negedge clock);
        meas_upd = 5'h00;
        repeat (3) @(negedge clock);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang in the read model must not stall the run forever.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        rst = 1'b1;
        jam_clear = 1'b0;
        link = 6'h00;
        meas = {n5, nt, nm, ns, nb};
        meas_upd = 5'h00;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        rows[0]=mk(6'h00,nb,ns,nm,nt,n5,16'h0000,16'h0000);
        rows[1]=mk(6'h20,nb,ns,nm,nt,n5,16'h0001,16'h0050);
        rows[2]=mk(6'h10,nb,ns,nm,nt,n5,16'h0002,16'h0004);
        rows[3]=mk(6'h08,nb,ns,nm,nt,n5,16'h0004,16'h0003);
        rows[4]=mk(6'h0A,nb,ns,nm,nt,n5,16'h0004,16'h0000);
        rows[5]=mk(6'h00,16'h0071,ns,nm,nt,n5,16'h0008,16'h0005);
        rows[6]=mk(6'h00,16'h00B0,ns,nm,nt,n5,16'h0008,16'h0005);
        rows[7]=mk(6'h00,16'h0072,ns,nm,nt,n5,16'h0000,16'h0020);
        rows[8]=mk(6'h00,nb,16'h0149,nm,nt,n5,16'h0008,16'h0002);
        rows[9]=mk(6'h00,nb,16'h0187,nm,nt,n5,16'h0008,16'h0002);
        rows[10]=mk(6'h02,nb,16'h0149,nm,nt,n5,16'h0000,16'h0000);
        rows[11]=mk(6'h00,nb,ns,16'h0DAD,nt,n5,16'h0000,16'h0010);
        rows[12]=mk(6'h00,nb,ns,nm,16'hFFFF,n5,16'h0008,16'h0030);
        rows[13]=mk(6'h00,nb,ns,nm,16'h00B1,n5,16'h0008,16'h0030);
        rows[14]=mk(6'h00,nb,ns,nm,nt,16'h01C1,16'h0008,16'h0040);
        rows[15]=mk(6'h00,nb,ns,nm,nt,16'h0227,16'h0008,16'h0040);
        rows[16]=mk(6'h01,nb,ns,nm,nt,n5,16'h0000,16'h0100);
        rows[17]=mk(6'h38,16'h0071,ns,nm,nt,n5,16'h000F,16'h0005);
        rows[18]=mk(6'h30,16'h0078,ns,16'h0DAD,16'h00B1,16'h0227,
                    16'h000B,16'h0004);
        rows[19]=mk(6'h00,16'h0078,ns,16'h0DAD,nt,n5,16'h0000,16'h0010);
        repeat (2) @(negedge clock);
        chk("err_bits", 16'h0000, err_bits);
        chk("ind_code", 16'h0000, ind_code);
        rst = 1'b0;
        for (int k = 0; k < 20; k++) begin
            apply(rows[k]);
            chk("err_bits", rows[k].err, err_bits);
            chk("ind_code", rows[k].ind, ind_code);
            rd_chk(ERR_REG_NUM, rows[k].err);
            rd_chk(IND_REG_NUM, rows[k].ind);
        end
        apply(rows[0]);
        rd_chk(16'h0008, 16'h0000);
        samp(M_MOTOR, 16'h1195);
        chk("ind_code", IND_JAM, ind_code);
        chk("err_bits", 16'h0000, err_bits);
        samp(M_MOTOR, 16'h0000);
        chk("ind_code", IND_JAM, ind_code);
        samp(M_SUP36, 16'h0149);
        chk("ind_code", IND_JAM, ind_code);
        samp(M_BATT, 16'h0071);
        chk("ind_code", IND_RED5, ind_code);
        samp(M_BATT, nb);
        samp(M_SUP36, ns);
        @(negedge clock);
        jam_clear = 1'b1;
        @(negedge clock);
        jam_clear = 1'b0;
        repeat (3) @(negedge clock);
        chk("ind_code", IND_OK, ind_code);
        link.mot_fault = 1'b1;
        jam_clear = 1'b1;
        repeat (3) @(negedge clock);
        chk("ind_code", IND_JAM, ind_code);
        link.mot_fault = 1'b0;
        repeat (3) @(negedge clock);
        chk("ind_code", IND_OK, ind_code);
        jam_clear = 1'b0;
        samp(M_BATT, 16'h0071);
        meas[M_BATT] = nb;
        link.mot_fail = 1'b1;
        repeat (3) @(negedge clock);
        chk("ind_code", IND_RED5, ind_code);
        rd_chk(ERR_REG_NUM, 16'h000C);
        link.mot_fail = 1'b0;
        samp(M_BATT, nb);
        link.gps_fail = 1'b1;
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        chk("err_bits", 16'h0000, err_bits);
        chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk("err_bits", 16'h0001, err_bits);
        end_of_test();
    end
endmodule
`default_nettype wire
